// ==== pkg/ecr_map.vh ====
/*
  address map, field positions, reset values and mode codes of the
  extended control block of the parallel port.
  assumes: included by the design files by bare name; offsets are
  relative to the port base address already decoded by the host side.
*/
// Overview of operation
// - compression bit of the resource config register always reads zero
// - line-level bit reads the live level of the interrupt request line
// - mode field, top three bits of extended control, is read/write
// - ecp mode, fault enabled: interrupt pulse on each fault falling edge
// - ecp mode: clearing fault disable while fault asserted raises an interrupt
// - dma runs only while dma enabled and service mask is zero
// - service mask set suppresses dma and all service interrupts
// - hardware sets service mask on any service interrupt; software clears
// - software writing one to service mask never interrupts
// - dma enabled: terminal count sets service mask
// - pio forward: enough free bytes sets service mask
// - pio reverse: enough stored bytes sets service mask
// - full flag reads one when fifo cannot take another byte
// - empty flag reads one when fifo holds nothing
// - standard mode: fifo held reset, open collector controls, no tristate
// - bidirectional: direction tristates data; modes above push-pull
// - fifo mode: fifo bytes sent with compatibility handshake, forward only
// - ecp forward: command and payload queues share one fifo, sent out
// - ecp reverse: received bytes enter fifo for software or dma
// - mode 100 is epp only with option set; 101 reserved
// - test mode: fifo read and written, never sent with handshake
// - configuration mode: config registers at 0x400 and 0x401
// - interrupt pin driven low briefly, then released
// - only from standard or bidirectional may any mode be chosen
`ifndef ECR_MAP_VH
`define ECR_MAP_VH
`define OFS_QUEUE 11'h400
`define OFS_RESCFG 11'h401
`define OFS_ECR 11'h402
`define OFS_CMDQ 11'h000
`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_FAULTDIS 4
`define ECR_DMA_TRANSFER_ENABLE 3
`define ECR_SVCMASK 2
`define ECR_FULL 1
`define ECR_EMPTY 0
`define CFG_COMPRESS 7
`define CFG_IRQLVL 6
`define ECR_RESET 8'h15
`define CAPCFG_VALUE 8'h10
`define RESCFG_RESET 6'h00
`define MODE_STD 3'h0
`define MODE_BIDIR 3'h1
`define MODE_FIFO 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_RSVD 3'h5
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7
`define IRQ_PULSE_NS 100
`define CLK_PERIOD_NS 25
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== src/byte_fifo.v ====
/*
  synchronous fifo with valid/ready on both sides and a fill count.
  assumes: single clock, synchronous active-low reset, flush is a level.
*/
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire flush,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady,
  output reg [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  wire push;
  wire pop;
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr];

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk) begin
    if (!rst_b || flush) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// ==== src/ecp_ext_control.v ====
/*
  extended control register bank of the parallel port: mode select,
  fault interrupt, dma gating, service interrupt, fifo status and the
  configuration registers, with the shared 16-byte data fifo.
  assumes: host register strobes are one-cycle pulses synchronous to clk,
  the protocol engines outside drain/fill the fifo through the link ports,
  and the irq pin wire is resolved outside from irqOut and irqOe.
*/
`include "ecr_map.vh"

module ecp_ext_control #(
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter [AW:0] TX_FREE_LEVEL = 5'd8,
  parameter [AW:0] RX_FILL_LEVEL = 5'd8
) (
  input wire clk,
  input wire rst_b,
  input wire [10:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  input wire direction,
  input wire eppOptionConfig,
  input wire peripheralFault_n,
  input wire dmaTerminalCount,
  output wire dmaRequest,
  input wire irqLineLevel,
  output wire irqOut,
  output wire irqOe,
  output wire faultIrq,
  output wire controlsOpenCollector,
  output wire dataTristate,
  output wire eppEnable,
  output wire [8:0] txData,
  output wire txValid,
  input wire txReady,
  input wire [7:0] rxData,
  input wire rxValid,
  output wire rxReady,
  output wire [2:0] portMode
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [2:0] mode;
  reg faultIrqDisable;
  reg dmaTransferEnable;
  reg serviceMask;
  reg [5:0] portResourceConfig;
  reg faultPrev;
  reg [2:0] irqTimer;
  reg faultPulse;
  reg [7:0] lastPopped;

  localparam [7:0] ECR_INIT = `ECR_RESET;
  localparam integer IRQ_CYC = `IRQ_PULSE_CYC;

  wire [AW:0] fill;
  wire fifoFull;
  wire fifoEmpty;
  wire [8:0] fifoOut;
  wire fifoOutValid;
  wire fifoInReady;
  wire fifoPush;
  wire [8:0] fifoIn;
  wire fifoPop;

  function isQueueAccess;
    input [10:0] a;
    input [2:0] m;
    begin
      isQueueAccess = (a == `OFS_QUEUE) &&
        (m == `MODE_FIFO || m == `MODE_ECP || m == `MODE_TEST);
    end
  endfunction

  assign portMode = mode;

  // ----------------------------------------------------------------
  // pin driver control
  // ----------------------------------------------------------------
  assign controlsOpenCollector = (mode == `MODE_STD);
  // direction does not tristate the data lines in standard and fifo modes
  assign dataTristate = direction &&
    (mode != `MODE_STD) && (mode != `MODE_FIFO);
  assign eppEnable = (mode == `MODE_EPP) && eppOptionConfig;

  // ----------------------------------------------------------------
  // fifo and its two feeds
  // ----------------------------------------------------------------
  wire hostPush = regWr && (isQueueAccess(regAddr, mode) ||
    (regAddr == `OFS_CMDQ && mode == `MODE_ECP && !direction));
  wire hostPop = regRd && isQueueAccess(regAddr, mode);
  wire rxPath = (mode == `MODE_ECP) && direction;
  // address-queue bytes carry tag bit 8 so the ecp engine can tell them
  assign fifoIn = rxPath ? {1'b0, rxData} :
    {(regAddr == `OFS_CMDQ), regWrData};
  assign fifoPush = rxPath ? rxValid : hostPush;
  assign rxReady = rxPath & fifoInReady;
  // only forward fifo and forward ecp modes hand bytes to a handshake engine
  wire txPath = (mode == `MODE_FIFO && !direction) ||
    (mode == `MODE_ECP && !direction);
  assign txValid = txPath & fifoOutValid;
  assign txData = fifoOut;
  assign fifoPop = txPath ? txReady : hostPop;

  byte_fifo #(
    .WIDTH(9),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(mode == `MODE_STD),
    .inData(fifoIn),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .count(fill)
  );

  assign fifoFull = !fifoInReady;
  assign fifoEmpty = !fifoOutValid;

  // ----------------------------------------------------------------
  // service interrupt sources
  // ----------------------------------------------------------------
  wire freeEnough = (DEPTH[AW:0] - fill) >= TX_FREE_LEVEL;
  wire fillEnough = fill >= RX_FILL_LEVEL;
  wire svcCondition = dmaTransferEnable ? dmaTerminalCount :
    (direction ? fillEnough : freeEnough);
  // a level condition fires again as soon as the mask is cleared
  wire svcEvent = !serviceMask && svcCondition;
  assign dmaRequest = dmaTransferEnable && !serviceMask && (direction ?
    fifoOutValid : fifoInReady);

  // ----------------------------------------------------------------
  // fault interrupt
  // ----------------------------------------------------------------
  wire ecrWrite = regWr && (regAddr == `OFS_ECR);
  wire faultFall = faultPrev && !peripheralFault_n;
  wire faultRearm = ecrWrite && faultIrqDisable &&
    !regWrData[`ECR_FAULTDIS] && !peripheralFault_n;
  wire faultEvent = (mode == `MODE_ECP) &&
    ((!faultIrqDisable && faultFall) || faultRearm);
  assign faultIrq = faultPulse;

  always @(posedge clk) begin
    if (!rst_b) begin
      faultPrev <= 1'b1;
      faultPulse <= 1'b0;
    end else begin
      faultPrev <= peripheralFault_n;
      faultPulse <= faultEvent;
    end
  end

  // ----------------------------------------------------------------
  // extended control register writes
  // ----------------------------------------------------------------
  wire modeFree = (mode == `MODE_STD) || (mode == `MODE_BIDIR);
  wire modeTarget = (regWrData[7:5] == `MODE_STD) ||
    (regWrData[7:5] == `MODE_BIDIR);

  always @(posedge clk) begin
    if (!rst_b) begin
      mode <= ECR_INIT[`ECR_MODE_HI:`ECR_MODE_LO];
      faultIrqDisable <= 1'b1;
      dmaTransferEnable <= 1'b0;
      serviceMask <= 1'b1;
      portResourceConfig <= `RESCFG_RESET;
    end else begin
      if (ecrWrite) begin
        if (modeFree || modeTarget) begin
          mode <= regWrData[`ECR_MODE_HI:`ECR_MODE_LO];
        end
        faultIrqDisable <= regWrData[`ECR_FAULTDIS];
        dmaTransferEnable <= regWrData[`ECR_DMA_TRANSFER_ENABLE];
      end
      if (regWr && regAddr == `OFS_RESCFG && mode == `MODE_CFG) begin
        portResourceConfig <= regWrData[5:0];
      end
      // hardware set wins over a same-cycle software clear
      if (svcEvent) begin
        serviceMask <= 1'b1;
      end else if (ecrWrite) begin
        serviceMask <= regWrData[`ECR_SVCMASK];
      end
    end
  end

  // ----------------------------------------------------------------
  // shared interrupt pin: brief low pulse, then released
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      irqTimer <= 3'h0;
    end else if (svcEvent || faultEvent) begin
      irqTimer <= IRQ_CYC[2:0];
    end else if (irqTimer != 3'h0) begin
      irqTimer <= irqTimer - 1'b1;
    end
  end
  assign irqOut = 1'b0;
  assign irqOe = (irqTimer != 3'h0);

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // only host pops count; bytes the port engine drains are not remembered
  always @(posedge clk) begin
    if (!rst_b) begin
      lastPopped <= 8'h00;
    end else if (hostPop && fifoOutValid && !txPath) begin
      lastPopped <= fifoOut[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `OFS_ECR) begin
        regRdData <= {mode, faultIrqDisable, dmaTransferEnable,
          serviceMask, fifoFull, fifoEmpty};
      end else if (mode == `MODE_CFG && regAddr == `OFS_QUEUE) begin
        regRdData <= `CAPCFG_VALUE;
      end else if (mode == `MODE_CFG && regAddr == `OFS_RESCFG) begin
        regRdData <= {1'b0, irqLineLevel, portResourceConfig};
      end else if (hostPop) begin
        // an empty test fifo rereads the last byte taken from it
        regRdData <= fifoOutValid ? fifoOut[7:0] : lastPopped;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end
endmodule // ecp_ext_control

// ==== test/ecp_ext_control_checker.sv ====
/* port assertions for ecp_ext_control.
   assumes: bound to each instance; one clock, reset sync active low. */
module ecp_ext_control_checker (
  input wire clk,
  input wire rst_b,
  input wire [10:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  input wire irqLineLevel,
  input wire peripheralFault_n,
  input wire eppOptionConfig,
  input wire dmaRequest,
  input wire irqOut,
  input wire irqOe,
  input wire faultIrq,
  input wire controlsOpenCollector,
  input wire dataTristate,
  input wire eppEnable,
  input wire txValid,
  input wire [2:0] portMode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire cfgRd = regRd && regAddr == 11'h401 && portMode == 3'h7;
  wire ecrWr = regWr && regAddr == 11'h402;
  chk_cfg_bits: assert property (cfgRd |=> regRdData[7] == 1'b0
    && regRdData[6] == $past(irqLineLevel)) else $error("config bits");
  chk_mode_set: assert property (ecrWr && (portMode < 3'h2
    || regWrData[7:5] < 3'h2) |=> portMode == $past(regWrData[7:5]))
    else $error("mode not written");
  chk_mode_keep: assert property (ecrWr && portMode > 3'h1
    && regWrData[7:5] > 3'h1 |=> $stable(portMode)) else $error("mode moved");
  chk_svc_dma: assert property ($rose(irqOe) && !faultIrq
    |-> !dmaRequest) else $error("dma after service irq");
  chk_fault_cause: assert property (faultIrq |-> irqOe
    && !$past(peripheralFault_n)) else $error("fault irq no cause");
  // a retrigger inside the pulse would stretch it and fail this check, so the bench spaces events
  chk_irq_pulse: assert property ($rose(irqOe) |->
    (irqOe && !irqOut)[*4] ##1 !irqOe) else $error("irq pulse length");
  chk_std_mode: assert property (portMode == 3'h0
    |-> controlsOpenCollector && !dataTristate && ($past(portMode) != 3'h0
    || !txValid)) else $error("standard mode drivers");
  chk_epp_gate: assert property (eppEnable ==
    (portMode == 3'h4 && eppOptionConfig)) else $error("epp enable");
endmodule // ecp_ext_control_checker

bind ecp_ext_control ecp_ext_control_checker chk (.*);

// ==== test/port_peer.sv ====
/* printer side model: takes fifo bytes with random stalls, feeds a count.
   assumes: valid/ready link of ecp_ext_control, clock shared. */
module port_peer (
  input wire clk,
  input wire [8:0] txData,
  input wire txValid,
  output logic txReady,
  output wire [7:0] rxData,
  output logic rxValid,
  input wire rxReady,
  input wire rxOn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] seen[$];
  logic [7:0] cur = 8'ha0;
  // idle lines show junk so a stale byte never looks valid
  assign rxData = rxValid ? cur : ~cur;
  initial txReady = 1'b0;
  initial rxValid = 1'b0;
  always @(posedge clk) begin
    if (txValid && txReady) seen.push_back(txData);
    txReady <= 1'($urandom_range(1, 0));
    if (rxValid && rxReady) cur <= cur + 8'h01;
    rxValid <= rxOn;
  end
endmodule // port_peer

// ==== test/test_parallel_port_extended_control.sv ====
/* self-checking bench of ecp_ext_control with a printer side model.
   assumes: checker bound in its own file, defaults of the levels (8). */
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module test_parallel_port_extended_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, regWr = 0, regRd = 0, direction = 0, rxOn = 0;
  logic peripheralFault_n = 1, dmaTerminalCount = 0, oePrev = 0;
  logic eppOptionConfig = 0, irqLineLevel = 0;
  logic [10:0] regAddr = 0;
  logic [7:0] regWrData = 0, r, q[$];
  wire [7:0] regRdData, rxData;
  wire [8:0] txData;
  wire [2:0] portMode;
  wire dmaRequest, irqOut, irqOe, faultIrq, controlsOpenCollector;
  wire dataTristate, eppEnable, txValid, txReady, rxValid, rxReady;
  int errors = 0, checks = 0, irqs = 0, faults = 0, n, m;
  ecp_ext_control uut (.*);
  port_peer peer (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    oePrev <= irqOe;
    if (irqOe && !oePrev) irqs++;
    if (faultIrq) faults++;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1 `CHK("regRdData", e, regRdData)
  endtask
  task automatic drain(input int k);
    repeat (k) rd(11'h400, q.pop_front());
  endtask
  // ecr as read back: written bits 7..2 plus the two live fifo flags
  function automatic logic [7:0] ecr_exp(input logic [7:0] w,
      input logic full, input logic empty);
    return {w[7:2], full, empty};
  endfunction
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic close_out;
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    close_out;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h033c7312));
    repeat (3) @(posedge clk);
    rst_b <= 1;
    eppOptionConfig <= 1'($urandom_range(1, 0));
    irqLineLevel <= 1'($urandom_range(1, 0));
    rd(11'h402, 8'h15);
    wr(11'h402, 8'he4);
    r = 8'($urandom);
    wr(11'h401, r);
    rd(11'h401, {1'b0, irqLineLevel, r[5:0]});
    rd(11'h400, 8'h10);
    wr(11'h402, 8'hd4);
    rd(11'h402, 8'hf5);
    wr(11'h402, 8'h14);
    wr(11'h402, 8'hd4);
    for (n = 0; n < 17; n++) begin
      r = 8'($urandom);
      if (n < 16) q.push_back(r);
      if (n == 15) m = r;
      wr(11'h400, r);
      if (n == 0) rd(11'h402, ecr_exp(8'hd4, 1'b0, 1'b0));
    end
    rd(11'h402, ecr_exp(8'hd4, 1'b1, 1'b0));
    drain(16);
    rd(11'h400, m[7:0]);
    rd(11'h402, ecr_exp(8'hd4, 1'b0, 1'b1));
    m = irqs;
    wr(11'h402, 8'hd0);
    idle(8);
    rd(11'h402, 8'hd5);
    wr(11'h402, 8'hd4);
    idle(8);
    `CHK("irqs", m + 1, irqs)
    direction <= 1;
    wr(11'h402, 8'hd0);
    m = irqs;
    wr(11'h402, 8'hd4);
    idle(8);
    `CHK("irqs", m, irqs)
    wr(11'h402, 8'hd0);
    for (n = 0; n < 8; n++) begin
      r = 8'($urandom);
      q.push_back(r);
      if (n == 7) rd(11'h402, 8'hd0);
      wr(11'h400, r);
    end
    idle(8);
    rd(11'h402, 8'hd4);
    drain(8);
    direction <= 0;
    wr(11'h402, 8'hd8);
    rd(11'h402, 8'hd9);
    `CHK("dmaRequest", 1'b1, dmaRequest)
    dmaTerminalCount <= 1;
    @(posedge clk);
    dmaTerminalCount <= 0;
    idle(8);
    rd(11'h402, 8'hdd);
    `CHK("dmaRequest", 1'b0, dmaRequest)
    wr(11'h402, 8'h14);
    wr(11'h402, 8'h34);
    wr(11'h402, 8'h94);
    #1 `CHK("eppEnable", eppOptionConfig, eppEnable)
    wr(11'h402, 8'h34);
    wr(11'h402, 8'h64);
    m = faults;
    peripheralFault_n <= 0;
    idle(8);
    `CHK("faults", m + 1, faults)
    wr(11'h402, 8'h74);
    wr(11'h402, 8'h64);
    idle(8);
    `CHK("faults", m + 2, faults)
    peripheralFault_n <= 1;
    wr(11'h402, 8'h74);
    peripheralFault_n <= 0;
    idle(8);
    `CHK("faults", m + 2, faults)
    r = 8'($urandom);
    wr(11'h000, r);
    wr(11'h400, ~r);
    idle(20);
    `CHK("cmdByte", {1'b1, r}, peer.seen[0])
    `CHK("dataByte", {1'b0, ~r}, peer.seen[1])
    wr(11'h402, 8'h34);
    direction <= 1;
    wr(11'h402, 8'h74);
    rxOn <= 1;
    #1 `CHK("dataTristate", 1'b1, dataTristate)
    `CHK("controlsOpenCollector", 1'b0, controlsOpenCollector)
    idle(30);
    rd(11'h400, 8'ha0);
    rd(11'h400, 8'ha1);
    wr(11'h402, 8'h14);
    #1 `CHK("dataTristate", 1'b0, dataTristate)
    `CHK("controlsOpenCollector", 1'b1, controlsOpenCollector)
    rd(11'h402, 8'h15);
    close_out;
  end
endmodule // test_parallel_port_extended_control
